// ==== iopoc_top.sv ====
// Configuration word logic for output 1, input polarity and move start alignment.
//
// What this block does
// - Role 0: output 1 conducts until fault.
// - Role 1: output 1 follows command data bit.
// - Output 1 is ON until configured.
// - Loss bits act only in general purpose role.
// - Loss action 0 keeps last output level.
// - Loss action 1 forces output to loss level.
// - Sync bit 0 starts move right after read.
// - Sync bit 1 holds move for clock pulse.
// - Polarity bits choose conducting or non-conducting active.
// - Unused input with polarity 1 reads inactive.
// - Encoder inputs report their polarity bit instead.
// - Reserved bit written as one flags error.
// - Encoder without A and B inputs flags error.
`include "iopoc_cfg.svh"
`timescale 1ns/1ps
module iopoc_top
  import iopoc_pkg::*;
#(
  parameter int NUM_IN = `IOPOC_NUM_IN,
  parameter int CFG_W = `IOPOC_CFG_W
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Configuration word port
  input wire logic CFG_WE_I,
  input wire logic [CFG_W-1:0] CFG_WDATA_I,
  output logic [CFG_W-1:0] CFG_RDATA_O,
  output logic CFG_VALID_O,
  output logic CFG_ERR_O,
  // Encoder assignment from the input assignment word
  input wire logic ENC_ENABLE_I,
  input wire iopoc_in_func_t IN_FUNC_I,
  // Output 1 sources
  input wire logic FAULT_I,
  input wire logic CMD_OUT1_I,
  input wire logic LINK_LOST_I,
  output logic OUT1_O,
  // Discrete inputs
  input wire logic [NUM_IN-1:0] IN_RAW_I,
  output logic [NUM_IN-1:0] IN_STATE_O,
  // Move release
  input wire logic MOVE_REQ_I,
  input wire logic DC_PULSE_I,
  output logic MOVE_START_O
);

  initial begin
    if (NUM_IN != `IOPOC_NUM_IN) begin
      $error("iopoc_top: NUM_IN must be 3");
    end
    if (CFG_W != `IOPOC_CFG_W) begin
      $error("iopoc_top: CFG_W must be 16");
    end
  end

  // Report level of one input: polarity picks the active sense, encoder use masks it.
  function automatic logic report_level(input logic raw, input logic pol, input logic enc);
    logic lvl;
    lvl = pol ? raw : ~raw;
    if (enc) begin
      lvl = pol;
    end
    return lvl;
  endfunction : report_level

  // Configuration storage.
  iopoc_cfg_t cfg_q;
  iopoc_cfg_t cfg_d;
  logic cfg_valid_q;
  logic cfg_valid_d;
  logic rsvd_err_q;
  logic rsvd_err_d;
  logic enc_err_q;
  logic enc_err_d;

  wire logic rsvd_hit;
  wire logic cfg_accept;
  wire logic [CFG_W-1:0] cfg_clean;

  assign rsvd_hit = |(CFG_WDATA_I & `IOPOC_RSVD_MASK);
  assign cfg_accept = CFG_WE_I & ~rsvd_hit;
  assign cfg_clean = CFG_WDATA_I & ~`IOPOC_IGNORED_MASK;

  // The whole word is taken in one edge so no setting lags another.
  assign cfg_d = cfg_accept ? iopoc_cfg_t'(cfg_clean) : cfg_q;
  assign cfg_valid_d = cfg_valid_q | cfg_accept;
  assign rsvd_err_d = CFG_WE_I ? rsvd_hit : rsvd_err_q;

  wire logic enc_a_ok;
  wire logic enc_b_ok;

  assign enc_a_ok = (IN_FUNC_I.func_a == `IOPOC_FUNC_ENC_A);
  assign enc_b_ok = (IN_FUNC_I.func_b == `IOPOC_FUNC_ENC_B);
  assign enc_err_d = ENC_ENABLE_I & ~(enc_a_ok & enc_b_ok);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cfg_q <= iopoc_cfg_t'(`IOPOC_CFG_RESET);
      cfg_valid_q <= 1'b0;
      rsvd_err_q <= 1'b0;
      enc_err_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      cfg_valid_q <= cfg_valid_d;
      rsvd_err_q <= rsvd_err_d;
      enc_err_q <= enc_err_d;
    end
  end

  assign CFG_RDATA_O = cfg_q;
  assign CFG_VALID_O = cfg_valid_q;
  assign CFG_ERR_O = rsvd_err_q | enc_err_q;

  // Output 1.
  logic gp_level_q;
  logic gp_level_d;
  logic out1_q;
  logic out1_d;

  wire logic role_gp;
  wire logic gp_value;

  assign role_gp = cfg_q.output_role_select;

  // While the link is down the last commanded level is frozen.
  assign gp_level_d = LINK_LOST_I ? gp_level_q : CMD_OUT1_I;

  // Loss handling only matters in the general purpose role.
  assign gp_value = !LINK_LOST_I ? CMD_OUT1_I :
                    cfg_q.output_loss_action ? cfg_q.output_loss_level :
                    gp_level_q;

  always_comb begin
    out1_d = `IOPOC_OUT1_POWERUP;
    if (!cfg_valid_q) begin
      out1_d = `IOPOC_OUT1_POWERUP;
    end else if (role_gp) begin
      out1_d = gp_value;
    end else begin
      out1_d = ~FAULT_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      gp_level_q <= 1'b0;
      out1_q <= `IOPOC_OUT1_POWERUP;
    end else begin
      gp_level_q <= gp_level_d;
      out1_q <= out1_d;
    end
  end

  assign OUT1_O = out1_q;

  // Discrete inputs.
  logic [NUM_IN-1:0] in_sync;
  logic [NUM_IN-1:0] in_state_q;
  logic [NUM_IN-1:0] in_state_d;

  wire logic [NUM_IN-1:0] pol;
  wire logic [NUM_IN-1:0] enc_use;

  assign pol = {cfg_q.input_c_polarity, cfg_q.input_b_polarity, cfg_q.input_a_polarity};

  // Only inputs a and b can carry encoder channels.
  assign enc_use = {1'b0, ENC_ENABLE_I & enc_b_ok, ENC_ENABLE_I & enc_a_ok};

  iopoc_sync #(
    .WIDTH(NUM_IN)
  ) u_in_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_i(IN_RAW_I),
    .sync_o(in_sync)
  );

  // An unused input with polarity 1 never conducts, so it always reads inactive.
  assign in_state_d[0] = report_level(in_sync[0], pol[0], enc_use[0]);
  assign in_state_d[1] = report_level(in_sync[1], pol[1], enc_use[1]);
  assign in_state_d[2] = report_level(in_sync[2], pol[2], enc_use[2]);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      in_state_q <= '0;
    end else begin
      in_state_q <= in_state_d;
    end
  end

  assign IN_STATE_O = in_state_q;

  // Move release.
  logic clock_synchronised_move_lvl;
  logic dc_prev_q;
  logic start_q;
  logic start_d;
  iopoc_mv_state_t mv_q;
  iopoc_mv_state_t mv_d;

  wire logic dc_edge;
  wire logic dc_mode;

  iopoc_sync #(
    .WIDTH(1)
  ) u_clock_synchronised_move (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_i(DC_PULSE_I),
    .sync_o(clock_synchronised_move_lvl)
  );

  assign dc_edge = clock_synchronised_move_lvl & ~dc_prev_q;
  assign dc_mode = cfg_q.clock_synchronised_move;

  always_comb begin
    mv_d = mv_q;
    start_d = 1'b0;
    case (mv_q)
      IOPOC_MV_IDLE: begin
        if (MOVE_REQ_I && !dc_mode) begin
          start_d = 1'b1;
        end else if (MOVE_REQ_I) begin
          mv_d = IOPOC_MV_WAIT;
        end
      end
      IOPOC_MV_WAIT: begin
        if (dc_edge || !dc_mode) begin
          start_d = 1'b1;
          mv_d = IOPOC_MV_IDLE;
        end
      end
      default: begin
        mv_d = IOPOC_MV_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mv_q <= IOPOC_MV_IDLE;
      dc_prev_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      mv_q <= mv_d;
      dc_prev_q <= clock_synchronised_move_lvl;
      start_q <= start_d;
    end
  end

  assign MOVE_START_O = start_q;

endmodule : iopoc_top

// ==== iopoc_cfg.svh ====
// Offsets, masks, reset values and codes of the I/O polarity and output configuration block.
`ifndef IOPOC_CFG_SVH
`define IOPOC_CFG_SVH

`define IOPOC_CFG_W 16
`define IOPOC_CFG_RESET 16'h0000
`define IOPOC_IGNORED_MASK 16'h8000
`define IOPOC_RSVD_MASK 16'h0fb8
`define IOPOC_ROLE_BIT 14
`define IOPOC_LOSS_ACT_BIT 13
`define IOPOC_LOSS_LVL_BIT 12
`define IOPOC_CLOCK_SYNCHRONISED_MOVE_BIT 6
`define IOPOC_POL_LSB 0
`define IOPOC_NUM_IN 3
`define IOPOC_FUNC_W 3
`define IOPOC_FUNC_ENC_A 3'h7
`define IOPOC_FUNC_ENC_B 3'h7
`define IOPOC_OUT1_POWERUP 1'b1

`endif

// ==== iopoc_pkg.sv ====
// Types shared by the I/O polarity and output configuration block.
package iopoc_pkg;

  // Layout of the stored configuration word, most significant bit first.
  typedef struct packed {
    logic ignored;
    logic output_role_select;
    logic output_loss_action;
    logic output_loss_level;
    logic [4:0] rsvd_hi;
    logic clock_synchronised_move;
    logic [2:0] rsvd_lo;
    logic input_c_polarity;
    logic input_b_polarity;
    logic input_a_polarity;
  } iopoc_cfg_t;

  typedef enum logic [0:0] {
    IOPOC_MV_IDLE = 1'b0,
    IOPOC_MV_WAIT = 1'b1
  } iopoc_mv_state_t;

  // Function codes of inputs a and b as set by the input assignment word.
  typedef struct packed {
    logic [2:0] func_b;
    logic [2:0] func_a;
  } iopoc_in_func_t;

endpackage : iopoc_pkg

// ==== iopoc_sync.sv ====
// Two flip-flop synchroniser for pin-level inputs.
`timescale 1ns/1ps
module iopoc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  initial begin
    if (WIDTH < 1) begin
      $error("iopoc_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : iopoc_sync

// ==== iopoc_top_props.sv ====
// Port checker of the configuration block.
`timescale 1ns/1ps
`include "iopoc_cfg.svh"
module iopoc_top_props
  import iopoc_pkg::*;
#(
  parameter int NUM_IN = 3,
  parameter int CFG_W = 16
) (
  // Watched ports
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CFG_WE_I,
  input wire logic [CFG_W-1:0] CFG_WDATA_I,
  input wire logic [CFG_W-1:0] CFG_RDATA_O,
  input wire logic CFG_VALID_O,
  input wire logic CFG_ERR_O,
  input wire logic ENC_ENABLE_I,
  input wire iopoc_in_func_t IN_FUNC_I,
  input wire logic FAULT_I,
  input wire logic CMD_OUT1_I,
  input wire logic LINK_LOST_I,
  input wire logic OUT1_O,
  input wire logic [NUM_IN-1:0] IN_RAW_I,
  input wire logic [NUM_IN-1:0] IN_STATE_O,
  input wire logic MOVE_REQ_I,
  input wire logic DC_PULSE_I,
  input wire logic MOVE_START_O
);
  wire gp = CFG_VALID_O && CFG_RDATA_O[14];
  wire bad = |(CFG_WDATA_I & `IOPOC_RSVD_MASK);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  a_fault_role: assert property (
    CFG_VALID_O && !gp |=> OUT1_O != $past(FAULT_I))
    else $error("fault role");
  a_gp_follow: assert property (gp && !LINK_LOST_I |=> OUT1_O == $past(CMD_OUT1_I))
    else $error("gp level");
  a_unconfig_on: assert property (!CFG_VALID_O |=> OUT1_O)
    else $error("not on");
  a_loss_force: assert property (
    gp && CFG_RDATA_O[13] && LINK_LOST_I |=> OUT1_O == $past(CFG_RDATA_O[12]))
    else $error("loss level");
  a_move_now: assert property (!CFG_RDATA_O[6] && MOVE_REQ_I |=> MOVE_START_O)
    else $error("no start");
  a_sync_pulse: assert property (
    MOVE_START_O && $past(CFG_RDATA_O[6]) && $past(CFG_RDATA_O[6], 4)
    |-> $past(DC_PULSE_I, 3) && !$past(DC_PULSE_I, 4))
    else $error("early start");
  a_rsvd_refuse: assert property (
    CFG_WE_I && bad |=> CFG_ERR_O && $stable(CFG_RDATA_O))
    else $error("bad word kept");
  a_cfg_store: assert property (
    CFG_WE_I && !bad |=> CFG_VALID_O && CFG_RDATA_O == ($past(CFG_WDATA_I) & 16'h7fff))
    else $error("word lost");
endmodule : iopoc_top_props
bind iopoc_top iopoc_top_props #(.NUM_IN(NUM_IN), .CFG_W(CFG_W)) u_props (
  .CLK_I(CLK_I),
  .RST_N_I(RST_N_I),
  .CFG_WE_I(CFG_WE_I),
  .CFG_WDATA_I(CFG_WDATA_I),
  .CFG_RDATA_O(CFG_RDATA_O),
  .CFG_VALID_O(CFG_VALID_O),
  .CFG_ERR_O(CFG_ERR_O),
  .ENC_ENABLE_I(ENC_ENABLE_I),
  .IN_FUNC_I(IN_FUNC_I),
  .FAULT_I(FAULT_I),
  .CMD_OUT1_I(CMD_OUT1_I),
  .LINK_LOST_I(LINK_LOST_I),
  .OUT1_O(OUT1_O),
  .IN_RAW_I(IN_RAW_I),
  .IN_STATE_O(IN_STATE_O),
  .MOVE_REQ_I(MOVE_REQ_I),
  .DC_PULSE_I(DC_PULSE_I),
  .MOVE_START_O(MOVE_START_O)
);

// ==== iopoc_master.sv ====
// Fieldbus master model writing configuration and command data.
`timescale 1ns/1ps
module iopoc_master (
  // Clock
  input wire logic clk_i,
  // Requests
  output logic we_o,
  output logic [15:0] wdata_o,
  output logic cmd_o,
  output logic req_o
);
  initial begin
    we_o = 1'b0;
    wdata_o = '0;
    cmd_o = 1'b0;
    req_o = 1'b0;
  end
  // Reserved fields carry zero unless a refusal is being provoked.
  task put_cfg(input logic [15:0] d);
    @(posedge clk_i);
    we_o <= 1'b1;
    wdata_o <= d;
    @(posedge clk_i);
    we_o <= 1'b0;
  endtask : put_cfg
  task put_cmd(input logic v);
    cmd_o <= v;
  endtask : put_cmd
  task put_req();
    @(posedge clk_i);
    req_o <= 1'b1;
    @(posedge clk_i);
    req_o <= 1'b0;
  endtask : put_req
endmodule : iopoc_master

// ==== io_polarity_output_config_tb.sv ====
// Self-checking testbench of the configuration block.
`timescale 1ns/1ps
module io_polarity_output_config_tb;
  import iopoc_pkg::*;
  logic clk;
  logic rst_n;
  logic enc;
  logic fault;
  logic lost;
  logic dc;
  logic [2:0] raw;
  iopoc_in_func_t func;
  logic we, cmd, req, valid, err, out1, start;
  logic [15:0] wdata, rdata;
  logic [2:0] state;
  int fails = 0;
  int checks_done = 0;
  always #2 clk = ~clk;
  iopoc_master m (.clk_i(clk), .we_o(we), .wdata_o(wdata), .cmd_o(cmd), .req_o(req));
  iopoc_top dut (.CLK_I(clk), .RST_N_I(rst_n), .CFG_WE_I(we), .CFG_WDATA_I(wdata),
    .CFG_RDATA_O(rdata), .CFG_VALID_O(valid), .CFG_ERR_O(err), .ENC_ENABLE_I(enc),
    .IN_FUNC_I(func), .FAULT_I(fault), .CMD_OUT1_I(cmd), .LINK_LOST_I(lost),
    .OUT1_O(out1), .IN_RAW_I(raw), .IN_STATE_O(state), .MOVE_REQ_I(req),
    .DC_PULSE_I(dc), .MOVE_START_O(start));
  task chk(input logic [18:0] got, input logic [18:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task t_cfg();
    chk({out1, valid, err, rdata}, {3'b100, 16'h0});
    m.put_cfg(16'hc047);
    tick(0);
    chk({valid, err, rdata}, {2'b10, 16'h4047});
    for (int i = 3; i < 12; i++) begin
      if (i != 6) begin
        m.put_cfg(16'h0040 | (16'h1 << i));
        tick(0);
        chk({valid, err, rdata}, {2'b11, 16'h4047});
      end
    end
    $display("cfg done");
  endtask : t_cfg
  task t_out();
    m.put_cfg(16'h6000);
    m.put_cmd(1'b1);
    tick(2);
    chk({err, out1}, 2'b01);
    @(posedge clk);
    lost <= 1'b1;
    tick(2);
    chk(out1, 1'b0);
    @(posedge clk);
    lost <= 1'b0;
    m.put_cfg(16'h4000);
    lost <= 1'b1;
    m.put_cmd(1'b0);
    tick(2);
    chk(out1, 1'b1);
    // Loss level 0 differs from the healthy fault output, so honouring it would show.
    m.put_cfg(16'h2000);
    tick(2);
    chk(out1, 1'b1);
    @(posedge clk);
    fault <= 1'b1;
    tick(2);
    chk(out1, 1'b0);
    $display("out done");
  endtask : t_out
  task t_in();
    m.put_cfg(16'h0005);
    lost <= 1'b0;
    raw <= 3'b011;
    tick(4);
    chk(state, 3'b001);
    @(posedge clk);
    enc <= 1'b1;
    func <= 6'h3f;
    raw <= 3'b000;
    tick(4);
    chk({err, state}, 4'b0001);
    @(posedge clk);
    func <= 6'h07;
    tick(2);
    chk(err, 1'b1);
    $display("in done");
  endtask : t_in
  task t_move();
    m.put_req();
    tick(0);
    chk(start, 1'b1);
    m.put_cfg(16'h0045);
    m.put_req();
    tick(4);
    chk(start, 1'b0);
    @(posedge clk);
    dc <= 1'b1;
    tick(2);
    chk(start, 1'b0);
    tick(1);
    chk(start, 1'b1);
    @(posedge clk);
    dc <= 1'b0;
    $display("move done");
  endtask : t_move
  task conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  initial begin
    #20000;
    fails++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    enc = 1'b0;
    fault = 1'b0;
    lost = 1'b0;
    dc = 1'b0;
    raw = '0;
    func = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    t_cfg();
    t_out();
    t_in();
    t_move();
    conclude();
  end
endmodule : io_polarity_output_config_tb
